// ===== tcie_cfg.svh
// constants for the timer channel interrupt enable block
`ifndef TCIE_CFG_SVH
`define TCIE_CFG_SVH

`define TCIE_NCH 6
`define TCIE_AW 5
`define TCIE_DW 8

// register map
`define TCIE_ADDR_EN_BASE 5'h00
`define TCIE_ADDR_ST_BASE 5'h08
`define TCIE_ADDR_IRQ_ST 5'h10
`define TCIE_ADDR_IRQ_MASK 5'h11

// bit positions in the enable and status registers
`define TCIE_BIT_TRG 7
`define TCIE_BIT_DIR 7
`define TCIE_BIT_RSV 6
`define TCIE_BIT_UDF 5
`define TCIE_BIT_OVF 4
`define TCIE_BIT_D 3
`define TCIE_BIT_C 2
`define TCIE_BIT_B 1
`define TCIE_BIT_A 0

// reset values and per-channel-group masks
`define TCIE_EN_RST 8'h00
`define TCIE_ST_RST 8'h00
`define TCIE_IRQ_RST 6'h00
`define TCIE_EN_RD_ONES 8'h40
`define TCIE_EN_WMASK_DC 8'h9F
`define TCIE_EN_WMASK_U 8'hB3
`define TCIE_ST_MASK_DC 8'h1F
`define TCIE_ST_MASK_U 8'h33
`define TCIE_ST_RD_ONES_DC 8'hC0
`define TCIE_ST_RD_ONES_U 8'h40

`endif

// ===== tcie_pkg.sv
// types for the timer channel interrupt enable block
package tcie_pkg;

  // per-channel events from the counter and compare/capture logic, one-cycle pulses
  typedef struct packed {
    logic underflow;
    logic overflow;
    logic cmpcap_d;
    logic cmpcap_c;
    logic cmpcap_b;
    logic cmpcap_a;
  } tcie_evt_s;

  // per-channel gated interrupt request levels
  typedef struct packed {
    logic underflow_irq_req;
    logic overflow_irq_req;
    logic cmpcap_d_irq_req;
    logic cmpcap_c_irq_req;
    logic cmpcap_b_irq_req;
    logic cmpcap_a_irq_req;
  } tcie_req_s;

  typedef logic [7:0] tcie_byte_t;

endpackage : tcie_pkg

// ===== tcie_top.sv
// per-channel interrupt and conversion-trigger enable logic for a six-channel timer
`timescale 1ns/10ps
`default_nettype none
`include "tcie_cfg.svh"

// Contract
// - trigger enable gates compare A into conversion start
// - bit 6 reads one, writes ignored
// - channels 1,2,4,5: underflow request needs flag and enable
// - channels 0,3: underflow enable reserved, reads zero
// - overflow request needs flag and enable
// - channels 0,3: compare D request gated
// - channels 1,2,4,5: compare D enable reserved zero
// - channels 0,3: compare C request gated
// - channels 1,2,4,5: compare C enable reserved zero
// - compare B request needs flag and enable
// - compare A request needs flag and enable
// - six independent enable registers, one per channel
// - overflow flag set on counter wrap up
// - underflow flag set on counter wrap down
module tcie_top (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [`TCIE_AW-1:0] addr_i,
  input wire logic [`TCIE_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`TCIE_DW-1:0] rdata_o,
  input wire tcie_pkg::tcie_evt_s [`TCIE_NCH-1:0] evt_i,
  input wire logic [`TCIE_NCH-1:0] count_up_i,
  output tcie_pkg::tcie_req_s [`TCIE_NCH-1:0] req_o,
  output logic [`TCIE_NCH-1:0] conv_start_o,
  output logic irq_o
);

  // channels 0 and 3 carry compare C/D, the others carry underflow
  function automatic logic has_dc(input int ch);
    has_dc = (ch == 0) || (ch == 3);
  endfunction : has_dc

  function automatic tcie_pkg::tcie_byte_t en_wmask(input int ch);
    en_wmask = has_dc(ch) ? `TCIE_EN_WMASK_DC : `TCIE_EN_WMASK_U;
  endfunction : en_wmask

  function automatic tcie_pkg::tcie_byte_t st_mask(input int ch);
    st_mask = has_dc(ch) ? `TCIE_ST_MASK_DC : `TCIE_ST_MASK_U;
  endfunction : st_mask

  tcie_pkg::tcie_byte_t en_reg [`TCIE_NCH];
  tcie_pkg::tcie_byte_t en_next [`TCIE_NCH];
  tcie_pkg::tcie_byte_t flag_reg [`TCIE_NCH];
  tcie_pkg::tcie_byte_t flag_next [`TCIE_NCH];
  tcie_pkg::tcie_byte_t armed_reg [`TCIE_NCH];
  tcie_pkg::tcie_byte_t armed_next [`TCIE_NCH];
  tcie_pkg::tcie_byte_t evt_vec [`TCIE_NCH];
  logic [`TCIE_NCH-1:0] conv_reg;
  logic [`TCIE_NCH-1:0] conv_next;
  logic [`TCIE_NCH-1:0] req_any;
  logic [`TCIE_NCH-1:0] req_any_reg;
  logic [`TCIE_NCH-1:0] req_any_next;
  logic [`TCIE_NCH-1:0] irq_st_reg;
  logic [`TCIE_NCH-1:0] irq_st_next;
  logic [`TCIE_NCH-1:0] irq_mask_reg;
  logic [`TCIE_NCH-1:0] irq_mask_next;
  logic [`TCIE_DW-1:0] rdata_reg;
  logic [`TCIE_DW-1:0] rdata_next;
  logic [`TCIE_NCH-1:0] en_sel;
  logic [`TCIE_NCH-1:0] st_sel;
  logic irq_st_sel;
  logic irq_mask_sel;
  tcie_pkg::tcie_byte_t en_view [`TCIE_NCH];
  tcie_pkg::tcie_byte_t st_view [`TCIE_NCH];

  // register selects, decoded once and shared by the write, clear and read paths
  always_comb
  begin
    for (int ch = 0; ch < `TCIE_NCH; ch++)
    begin
      en_sel[ch] = (addr_i == `TCIE_ADDR_EN_BASE + 5'(ch));
      st_sel[ch] = (addr_i == `TCIE_ADDR_ST_BASE + 5'(ch));
    end
    irq_st_sel = (addr_i == `TCIE_ADDR_IRQ_ST);
    irq_mask_sel = (addr_i == `TCIE_ADDR_IRQ_MASK);
  end

  // event pulses laid out in status-register bit order
  always_comb
  begin
    for (int ch = 0; ch < `TCIE_NCH; ch++)
    begin
      evt_vec[ch] = `TCIE_ST_RST;
      evt_vec[ch][`TCIE_BIT_UDF] = evt_i[ch].underflow;
      evt_vec[ch][`TCIE_BIT_OVF] = evt_i[ch].overflow;
      evt_vec[ch][`TCIE_BIT_D] = evt_i[ch].cmpcap_d;
      evt_vec[ch][`TCIE_BIT_C] = evt_i[ch].cmpcap_c;
      evt_vec[ch][`TCIE_BIT_B] = evt_i[ch].cmpcap_b;
      evt_vec[ch][`TCIE_BIT_A] = evt_i[ch].cmpcap_a;
    end
  end

  // enable registers, one per channel
  always_comb
  begin
    for (int ch = 0; ch < `TCIE_NCH; ch++)
    begin
      en_next[ch] = en_reg[ch];
      if (wr_i && en_sel[ch])
      begin
        // reserved positions never take a one
        en_next[ch] = wdata_i & en_wmask(ch);
      end
    end
  end

  // status flags: hardware sets, software clears after reading a one
  always_comb
  begin
    for (int ch = 0; ch < `TCIE_NCH; ch++)
    begin
      flag_next[ch] = flag_reg[ch];
      armed_next[ch] = armed_reg[ch];
      if (rd_i && st_sel[ch])
      begin
        armed_next[ch] = armed_reg[ch] | flag_reg[ch];
      end
      if (wr_i && st_sel[ch])
      begin
        // only bits seen as one may be cleared; writing one leaves a flag alone
        flag_next[ch] = flag_reg[ch] & ~(armed_reg[ch] & ~wdata_i);
        armed_next[ch] = `TCIE_ST_RST;
      end
      // a new event wins over a clear in the same cycle
      flag_next[ch] = flag_next[ch] | (evt_vec[ch] & st_mask(ch));
    end
  end

  // gated requests are combinational so an enable change acts at once
  always_comb
  begin
    for (int ch = 0; ch < `TCIE_NCH; ch++)
    begin
      req_o[ch].underflow_irq_req = flag_reg[ch][`TCIE_BIT_UDF] && en_reg[ch][`TCIE_BIT_UDF] &&
                                    !has_dc(ch);
      req_o[ch].overflow_irq_req = flag_reg[ch][`TCIE_BIT_OVF] && en_reg[ch][`TCIE_BIT_OVF];
      req_o[ch].cmpcap_d_irq_req = flag_reg[ch][`TCIE_BIT_D] && en_reg[ch][`TCIE_BIT_D] &&
                                   has_dc(ch);
      req_o[ch].cmpcap_c_irq_req = flag_reg[ch][`TCIE_BIT_C] && en_reg[ch][`TCIE_BIT_C] &&
                                   has_dc(ch);
      req_o[ch].cmpcap_b_irq_req = flag_reg[ch][`TCIE_BIT_B] && en_reg[ch][`TCIE_BIT_B];
      req_o[ch].cmpcap_a_irq_req = flag_reg[ch][`TCIE_BIT_A] && en_reg[ch][`TCIE_BIT_A];
      req_any[ch] = |req_o[ch];
    end
  end

  // conversion start follows each compare A event by one cycle when the channel's trigger enable bit is set
  always_comb
  begin
    for (int ch = 0; ch < `TCIE_NCH; ch++)
    begin
      conv_next[ch] = evt_i[ch].cmpcap_a && en_reg[ch][`TCIE_BIT_TRG];
    end
  end

  // summary mask, owned by software
  always_comb
  begin
    irq_mask_next = irq_mask_reg;
    if (wr_i && irq_mask_sel)
    begin
      irq_mask_next = wdata_i[`TCIE_NCH-1:0];
    end
  end

  // summary status: a channel whose request set goes from none to some
  always_comb
  begin
    req_any_next = req_any;
    irq_st_next = irq_st_reg;
    if (wr_i && irq_st_sel)
    begin
      irq_st_next = irq_st_reg & ~wdata_i[`TCIE_NCH-1:0];
    end
    // set after clear so a same-cycle event is kept
    irq_st_next = irq_st_next | (req_any & ~req_any_reg);
  end

  // readback views per channel; reserved positions show their fixed values
  always_comb
  begin
    for (int ch = 0; ch < `TCIE_NCH; ch++)
    begin
      en_view[ch] = en_reg[ch] | `TCIE_EN_RD_ONES;
      if (has_dc(ch))
      begin
        st_view[ch] = flag_reg[ch] | `TCIE_ST_RD_ONES_DC;
      end
      else
      begin
        st_view[ch] = flag_reg[ch] | `TCIE_ST_RD_ONES_U;
        // direction bit is a live level, not a stored flag
        st_view[ch][`TCIE_BIT_DIR] = count_up_i[ch];
      end
    end
  end

  // read mux; data stand only in the cycle after the strobe
  always_comb
  begin
    rdata_next = `TCIE_EN_RST;
    if (rd_i)
    begin
      for (int ch = 0; ch < `TCIE_NCH; ch++)
      begin
        if (en_sel[ch])
        begin
          rdata_next = en_view[ch];
        end
        if (st_sel[ch])
        begin
          rdata_next = st_view[ch];
        end
      end
      if (irq_st_sel)
      begin
        rdata_next = {2'h0, irq_st_reg};
      end
      if (irq_mask_sel)
      begin
        rdata_next = {2'h0, irq_mask_reg};
      end
    end
  end

  // enable registers; reset wins over the clock enable in every group
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      for (int ch = 0; ch < `TCIE_NCH; ch++)
      begin
        en_reg[ch] <= `TCIE_EN_RST;
      end
    end
    else if (ce_i)
    begin
      for (int ch = 0; ch < `TCIE_NCH; ch++)
      begin
        en_reg[ch] <= en_next[ch];
      end
    end
  end

  // status flags and their read-one arming
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      for (int ch = 0; ch < `TCIE_NCH; ch++)
      begin
        flag_reg[ch] <= `TCIE_ST_RST;
        armed_reg[ch] <= `TCIE_ST_RST;
      end
    end
    else if (ce_i)
    begin
      for (int ch = 0; ch < `TCIE_NCH; ch++)
      begin
        flag_reg[ch] <= flag_next[ch];
        armed_reg[ch] <= armed_next[ch];
      end
    end
  end

  // conversion start pulses
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      conv_reg <= `TCIE_IRQ_RST;
    end
    else if (ce_i)
    begin
      conv_reg <= conv_next;
    end
  end

  // summary status and the request history that feeds its edge detector
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      req_any_reg <= `TCIE_IRQ_RST;
      irq_st_reg <= `TCIE_IRQ_RST;
    end
    else if (ce_i)
    begin
      req_any_reg <= req_any_next;
      irq_st_reg <= irq_st_next;
    end
  end

  // summary mask
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      irq_mask_reg <= `TCIE_IRQ_RST;
    end
    else if (ce_i)
    begin
      irq_mask_reg <= irq_mask_next;
    end
  end

  // read data register
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      rdata_reg <= `TCIE_EN_RST;
    end
    else if (ce_i)
    begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign conv_start_o = conv_reg;
  assign irq_o = |(irq_st_reg & irq_mask_reg);

endmodule : tcie_top
`default_nettype wire

// ===== tcie_top_monitor.sv
// port checker for the timer channel interrupt enable block
`timescale 1ns/10ps
`default_nettype none
`include "tcie_cfg.svh"
module tcie_top_monitor (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [`TCIE_AW-1:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [`TCIE_DW-1:0] rdata_o,
  input wire tcie_pkg::tcie_evt_s [`TCIE_NCH-1:0] evt_i,
  input wire tcie_pkg::tcie_req_s [`TCIE_NCH-1:0] req_o,
  input wire logic [`TCIE_NCH-1:0] conv_start_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_rd_en;
    rd_i && ce_i && addr_i < 5'h06;
  endsequence
  sequence s_rd_dc;
    rd_i && ce_i && (addr_i == 5'h00 || addr_i == 5'h03);
  endsequence
  sequence s_rd_u;
    rd_i && ce_i && addr_i inside {5'h01, 5'h02, 5'h04, 5'h05};
  endsequence
  a_rsv_one: assert property (s_rd_en |=> rdata_o[6]) else $error("bit 6 low");
  a_udf_rsv: assert property (s_rd_dc |=> !rdata_o[5]) else $error("udf enable set");
  a_d_rsv: assert property (s_rd_u |=> !rdata_o[3]) else $error("d enable set");
  a_c_rsv: assert property (s_rd_u |=> !rdata_o[2]) else $error("c enable set");
  a_conv_src: assert property (conv_start_o[1] |-> $past(evt_i[1].cmpcap_a)) else $error("stray start");
  a_udf_none: assert property (!req_o[0].underflow_irq_req && !req_o[3].underflow_irq_req) else $error("udf req");
  a_req_rise: assert property ($rose(req_o[2].overflow_irq_req) |-> $past(evt_i[2].overflow || wr_i))
    else $error("ovf req rose alone");
  a_req_fall: assert property ($fell(req_o[2].overflow_irq_req) |-> $past(wr_i)) else $error("ovf req fell");
  a_rst_quiet: assert property ($past(srst_i) |-> req_o == '0 && conv_start_o == '0) else $error("busy after reset");
endmodule : tcie_top_monitor
bind tcie_top tcie_top_monitor mon_u (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .addr_i(addr_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .evt_i(evt_i), .req_o(req_o), .conv_start_o(conv_start_o));
`default_nettype wire

// ===== tcie_far_model.sv
// converter trigger sink that counts start pulses
`timescale 1ns/10ps
`default_nettype none
module tcie_far_model (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [5:0] conv_start_i,
  output int n_conv_o
);
  // every start line that is high in a cycle counts as one conversion
  always @(posedge clk_i)
    if (srst_i)
      n_conv_o <= 0;
    else
      n_conv_o <= n_conv_o + $countones(conv_start_i);
endmodule : tcie_far_model
`default_nettype wire

// ===== test_timer_channel_irq_enable.sv
// self-checking bench for the enable block
`timescale 1ns/10ps
`default_nettype none
module test_timer_channel_irq_enable;
  logic clk_i = 0, srst_i = 1, ce_i = 1, wr_i = 0, rd_i = 0, irq_o;
  logic [4:0] addr_i = '0;
  logic [7:0] wdata_i = '0, rdata_o;
  logic [5:0] count_up_i = '0, conv_start_o;
  tcie_pkg::tcie_evt_s [5:0] evt_i = '0;
  tcie_pkg::tcie_req_s [5:0] req_o;
  int n_errors = 0, samples_checked = 0, n_conv, conv_m = 0, w, en_m[6], fl_m[6];
  always #2.5 clk_i = ~clk_i;
  tcie_top dut_u (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .evt_i(evt_i), .count_up_i(count_up_i), .req_o(req_o),
    .conv_start_o(conv_start_o), .irq_o(irq_o));
  tcie_far_model far_u (.clk_i(clk_i), .srst_i(srst_i), .conv_start_i(conv_start_o), .n_conv_o(n_conv));
  function int wm(int c);
    return (c % 3 == 0) ? 32'h9F : 32'hB3;
  endfunction : wm
  function int st(int c);
    return fl_m[c] | ((c % 3 == 0) ? 32'hC0 : {count_up_i[c], 7'h40});
  endfunction : st
  task close_out;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  task chk(input string nm, input int e, input logic [7:0] s);
    samples_checked++;
    if (s !== e[7:0])
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e[7:0], s);
    end
  endtask : chk
  task wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1;
    @(posedge clk_i);
    wr_i <= 0;
    #1;
  endtask : wr
  task rd(input logic [4:0] a, input int e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1;
    @(posedge clk_i);
    rd_i <= 0;
    #1 chk("rdata", e, rdata_o);
  endtask : rd
  task chkreq;
    for (int c = 0; c < 6; c++)
      chk("req", fl_m[c] & en_m[c] & 32'h3F, {2'b00, req_o[c]});
  endtask : chkreq
  task ev(input int c, input logic [5:0] b);
    @(posedge clk_i);
    evt_i[c] <= b;
    @(posedge clk_i);
    evt_i[c] <= '0;
    fl_m[c] |= b & wm(c) & 32'h3F;
    if (b[0] && en_m[c][7])
      conv_m++;
    #1;
  endtask : ev
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    close_out();
  end
  initial
  begin
    void'($urandom(13127));
    repeat (8) @(posedge clk_i);
    srst_i <= 0;
    for (int c = 0; c < 6; c++)
      rd(c, 32'h40);
    count_up_i <= 6'($urandom);
    for (int c = 0; c < 6; c++)
    begin
      // one channel keeps its trigger off so a start without enable would show
      w = (($urandom | 32'h91) & 32'hFF) ^ ((c == 5) ? 32'h80 : 0);
      en_m[c] = w & wm(c);
      wr(c, w);
      rd(c, en_m[c] | 32'h40);
    end
    for (int c = 0; c < 6; c++)
    begin
      ev(c, 6'h3F);
      chkreq();
    end
    repeat (2) @(posedge clk_i);
    chk("conv", conv_m, n_conv[7:0]);
    en_m[2] = 0;
    wr(2, 8'h00);
    chkreq();
    en_m[2] = 32'h10;
    wr(2, 8'h10);
    chkreq();
    chk("irq", 0, {7'h00, irq_o});
    wr(5'h11, 8'h3F);
    chk("irq", 1, {7'h00, irq_o});
    for (int c = 0; c < 6; c++)
    begin
      rd(8 + c, st(c));
      wr(8 + c, 8'h00);
      fl_m[c] = 0;
      chkreq();
    end
    wr(5'h10, 8'h3F);
    chk("irq", 0, {7'h00, irq_o});
    rd(5'h1F, 0);
    close_out();
  end
endmodule : test_timer_channel_irq_enable
`default_nettype wire
